// File: dcs_host_model.sv
module dcs_host_model (
    // clock
    input wire logic i_clk,
    // link pins
    output logic o_sclk,
    output logic o_chip_select_low_active,
    output logic o_sdi,
    input wire logic i_sdo,
    input wire logic i_sdo_oe,
    // finished read
    output logic o_rd_valid,
    output logic [15:0] o_rd_word
);
    timeunit 1ns;
    timeprecision 100ps;

    // link idles deselected with the clock parked low
    initial begin
        o_sclk = 1'b0;
        o_chip_select_low_active = 1'b1;
        o_sdi = 1'b0;
        o_rd_valid = 1'b0;
        o_rd_word = 16'h0000;
    end

    // idle data toggles so a stale bit never looks valid
    always @(posedge i_clk) begin
        if (o_chip_select_low_active) begin
            o_sdi <= ~o_sdi;
        end
    end

    // one frame of n clocks, ph+1 core cycles low and ph high per clock (slow host: larger ph)
    task automatic frame(input logic [15:0] w, input int n, input int ph);
        logic [15:0] rd;
        rd = 16'h0000;
        @(posedge i_clk) #1;
        o_chip_select_low_active = 1'b0;
        for (int k = 0; k < n; k++) begin
            o_sdi = w[k % 16]; // lsb first, bit 0 picks the word
            repeat (ph + 1) @(posedge i_clk);
            #1;
            // an undriven data out must never pass as a good bit
            if (k < 16) rd[k] = i_sdo_oe ? i_sdo : 1'bx;
            o_sclk = 1'b1;
            repeat (ph) @(posedge i_clk);
            #1;
            o_sclk = 1'b0;
        end
        repeat (ph) @(posedge i_clk);
        #1;
        o_chip_select_low_active = 1'b1; // commit on release
        o_rd_word = rd;
        o_rd_valid = (n == 16);
        @(posedge i_clk) #1;
        o_rd_valid = 1'b0;
        // leave off the edge so callers never sample or drive in its time step
        repeat (3) @(posedge i_clk);
        #1;
    endtask
endmodule

// File: dcs_ol_filter.sv
module dcs_ol_filter #(
    parameter int LIMIT = dcs_pkg::OL_FILTER_CYC
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rstn,
    // stage condition
    input wire logic i_active,
    input wire logic i_below,
    // filtered result
    output logic o_hit
);
    typedef struct packed {
        dcs_pkg::dcs_cnt_type cnt;
        logic hit;
    } dcs_filt_state_type;

    dcs_filt_state_type s;
    dcs_filt_state_type n;
    dcs_pkg::dcs_cnt_type last;

    // any break in the low-current run restarts the count, so glitches never flag
    always_comb begin
        n = s;
        last = dcs_pkg::dcs_cnt_type'(LIMIT - 1);
        n.hit = 1'h0;
        if (i_active && i_below) begin
            n.hit = (s.cnt == last);
            if (s.cnt != last) begin
                n.cnt = s.cnt + 1'h1;
            end
        end else begin
            n.cnt = '0;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            s <= '0;
        end else begin
            s <= n;
        end
    end

    assign o_hit = s.hit;

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rstn);

    a_ol_filter_time: assert property ($rose(o_hit) |-> $past(s.cnt) == last && $past(i_below))
        else $error("open-load hit before the full filter time");
endmodule

// File: dcs_pkg.sv
package dcs_pkg;
    // link framing
    localparam int FRAME_BITS = 16;
    localparam logic [4:0] FRAME_LEN = 5'h10;
    localparam logic [4:0] FRAME_SAT = 5'h11;
    localparam int SEL_BIT = 0;

    // first control word fields
    localparam int W0_RESET = 15;
    localparam int W0_OL_MASK = 14;
    localparam int W0_DUTY = 13;
    localparam int W0_SUPPLY_LATCH = 12;
    localparam int W0_STAGE_LO = 1;

    // second control word fields; bits above the enables hold nothing
    localparam int W1_REC_LO = 6;
    localparam int W1_PWM_LO = 1;
    localparam logic [15:0] W1_KEEP_MASK = 16'h07FE;

    // status word fields, shared by both words
    localparam int S_ALWAYS_ONE = 15;
    localparam int S_OV = 14;
    localparam int S_UV = 13;
    localparam int S_TSD = 12;
    localparam int S_TWARN = 11;
    localparam int S_NRDY = 10;
    localparam int S_UNUSED = 9;
    localparam int S_FLAG_LO = 1;
    localparam int S_NOERR = 0;

    // stages: one-ls, one-hs, two-ls, two-hs, three-ls, three-hs, four-hs, five-hs
    localparam int NSTAGE = 8;
    localparam int HALF_BRIDGES = 3;
    localparam logic [15:0] REG_RESET = 16'h0000;

    // timing, figures in microseconds, counts at the core clock
    localparam int CLK_MHZ = 250;
    localparam int OL_FILTER_TIME_US = 1000;
    localparam int SETTLE_TIME_US = 100;
    localparam int REC_DELAY_TIME_US = 20;
    localparam int OL_FILTER_CYC = OL_FILTER_TIME_US * CLK_MHZ;
    localparam int SETTLE_CYC = SETTLE_TIME_US * CLK_MHZ;
    localparam int REC_DELAY_CYC = REC_DELAY_TIME_US * CLK_MHZ;

    typedef logic [23:0] dcs_cnt_type;

    // output number (0 = first output) that a stage belongs to
    function automatic int stage_output(input int stage);
        case (stage)
            7: stage_output = 4;
            6: stage_output = 3;
            default: stage_output = stage / 2;
        endcase
    endfunction
endpackage

// File: dcs_regs_top.sv
module dcs_regs_top #(
    parameter int OL_FILTER_CYC = dcs_pkg::OL_FILTER_CYC,
    parameter int SETTLE_CYC = dcs_pkg::SETTLE_CYC,
    parameter int REC_DELAY_CYC = dcs_pkg::REC_DELAY_CYC
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rstn,
    // serial link
    input wire logic i_sclk,
    input wire logic i_chip_select_low_active,
    input wire logic i_sdi,
    output logic o_sdo,
    output logic o_sdo_oe,
    // protection monitors
    input wire logic [dcs_pkg::NSTAGE-1:0] i_overcurrent_event,
    input wire logic [dcs_pkg::NSTAGE-1:0] i_load_below_threshold,
    input wire logic i_supply_overvoltage,
    input wire logic i_supply_undervoltage,
    input wire logic i_thermal_shutdown,
    input wire logic i_temp_warning,
    input wire logic i_standby_exit,
    input wire logic i_pwm,
    // driver stage enables
    output logic [dcs_pkg::NSTAGE-1:0] o_stage_on
);
    typedef struct packed {
        logic [15:0] ctrl0;
        logic [15:0] ctrl1;
        logic [dcs_pkg::NSTAGE-1:0] oc_flag;
        logic [dcs_pkg::NSTAGE-1:0] oc_lock;
        logic [dcs_pkg::NSTAGE-1:0] ol_flag;
        logic [dcs_pkg::NSTAGE-1:0] stage_on;
        logic ov;
        logic uv;
        logic thermal_shutdown_flag;
        logic twarn;
        logic nrdy;
        logic rec_phase;
        dcs_pkg::dcs_cnt_type settle_cnt;
        dcs_pkg::dcs_cnt_type rec_cnt;
    } dcs_top_state_type;

    dcs_top_state_type s;
    dcs_top_state_type n;

    logic frame_valid;
    logic [15:0] frame_word;
    logic [15:0] status0;
    logic [15:0] status1;
    logic no_error;
    logic [dcs_pkg::NSTAGE-1:0] ol_hit;
    logic [dcs_pkg::NSTAGE-1:0] rec_en;
    logic [dcs_pkg::NSTAGE-1:0] pwm_en;
    logic [dcs_pkg::NSTAGE-1:0] want;
    logic clear_all;
    logic rec_tick;
    logic low_duty;
    logic retry;
    logic supply_off;
    logic hold_off;

    // shifter and frame checker
    dcs_serial_port u_port (
        .i_clk(i_clk),
        .i_rstn(i_rstn),
        .i_sclk(i_sclk),
        .i_chip_select_low_active(i_chip_select_low_active),
        .i_sdi(i_sdi),
        .o_sdo(o_sdo),
        .o_sdo_oe(o_sdo_oe),
        .i_status0(status0),
        .i_status1(status1),
        .o_frame_valid(frame_valid),
        .o_frame_word(frame_word)
    );

    // one low-current filter per stage, watching only stages that are driven
    for (genvar g = 0; g < dcs_pkg::NSTAGE; g++) begin : g_ol
        dcs_ol_filter #(
            .LIMIT(OL_FILTER_CYC)
        ) u_filt (
            .i_clk(i_clk),
            .i_rstn(i_rstn),
            .i_active(s.stage_on[g]),
            .i_below(i_load_below_threshold[g]),
            .o_hit(ol_hit[g])
        );
    end

    // status words; supply, thermal and ready flags appear in both
    always_comb begin
        no_error = ~(s.ov | s.uv | s.thermal_shutdown_flag | s.twarn | s.nrdy | (|s.oc_flag)
                   | ((|s.ol_flag) & ~s.ctrl0[dcs_pkg::W0_OL_MASK]));
        status0 = '0;
        status0[dcs_pkg::S_ALWAYS_ONE] = 1'h1;
        status0[dcs_pkg::S_OV] = s.ov;
        status0[dcs_pkg::S_UV] = s.uv;
        status0[dcs_pkg::S_TSD] = s.thermal_shutdown_flag;
        status0[dcs_pkg::S_TWARN] = s.twarn;
        status0[dcs_pkg::S_NRDY] = s.nrdy;
        status0[dcs_pkg::S_NOERR] = no_error;
        status1 = status0;
        status0[dcs_pkg::S_FLAG_LO +: dcs_pkg::NSTAGE] = s.oc_flag;
        status1[dcs_pkg::S_FLAG_LO +: dcs_pkg::NSTAGE] = s.ol_flag;
        status1[dcs_pkg::S_UNUSED] = 1'h0;
    end

    // per-stage enables picked out of the second control word
    always_comb begin
        rec_en = '0;
        pwm_en = '0;
        for (int i = 0; i < dcs_pkg::NSTAGE; i++) begin
            rec_en[i] = s.ctrl1[dcs_pkg::W1_REC_LO + dcs_pkg::stage_output(i)];
            pwm_en[i] = s.ctrl1[dcs_pkg::W1_PWM_LO + dcs_pkg::stage_output(i)];
        end
    end

    // next state: register writes, sticky flags, timers and stage drive
    always_comb begin
        n = s;
        want = '0;
        clear_all = frame_valid && !frame_word[dcs_pkg::SEL_BIT]
                    && frame_word[dcs_pkg::W0_RESET];

        // commit of a checked frame to the register its bit 0 names
        if (frame_valid) begin
            if (frame_word[dcs_pkg::SEL_BIT]) begin
                n.ctrl1 = frame_word & dcs_pkg::W1_KEEP_MASK;
            end else begin
                n.ctrl0 = frame_word;
            end
        end

        // shared retry clock; a fault landing just before a tick retries at once,
        // but only while its enable is set in the registered second control word
        rec_tick = (s.rec_cnt == dcs_pkg::dcs_cnt_type'(REC_DELAY_CYC - 1));
        n.rec_cnt = rec_tick ? '0 : s.rec_cnt + 1'h1;
        if (rec_tick) begin
            n.rec_phase = ~s.rec_phase;
        end
        // the low duty cycle skips every other tick; a hot die forces it
        low_duty = !s.ctrl0[dcs_pkg::W0_DUTY] || s.twarn;
        retry = rec_tick && (!low_duty || s.rec_phase);

        // sticky flags: a new event beats a clear in the same cycle
        n.oc_flag = (clear_all ? '0 : s.oc_flag) | i_overcurrent_event;
        n.oc_lock = ((clear_all ? '0 : s.oc_lock) & ~(retry ? rec_en : '0))
                    | i_overcurrent_event;
        n.ol_flag = (clear_all ? '0 : s.ol_flag) | ol_hit;
        n.ov = (!clear_all && s.ov) || i_supply_overvoltage;
        n.uv = (!clear_all && s.uv) || i_supply_undervoltage;
        n.thermal_shutdown_flag = (!clear_all && s.thermal_shutdown_flag) || i_thermal_shutdown;
        n.twarn = (!clear_all && s.twarn) || i_temp_warning;

        // settle timer after wake; the reset bit does not cut it short
        if (i_standby_exit) begin
            n.nrdy = 1'h1;
            n.settle_cnt = '0;
        end else if (s.nrdy) begin
            if (s.settle_cnt == dcs_pkg::dcs_cnt_type'(SETTLE_CYC - 1)) begin
                n.nrdy = 1'h0;
            end else begin
                n.settle_cnt = s.settle_cnt + 1'h1;
            end
        end

        // supply faults release by themselves unless latching is chosen
        supply_off = i_supply_overvoltage || i_supply_undervoltage
                     || (s.ctrl0[dcs_pkg::W0_SUPPLY_LATCH] && (n.ov || n.uv));
        // the warning flag is left out on purpose
        hold_off = supply_off || n.thermal_shutdown_flag || n.nrdy;

        // stage demand, with pwm gating where enabled
        for (int i = 0; i < dcs_pkg::NSTAGE; i++) begin
            want[i] = s.ctrl0[dcs_pkg::W0_STAGE_LO + i] && !n.oc_lock[i]
                      && (!pwm_en[i] || i_pwm);
        end
        // both sides of a half bridge asked on would short the supply
        for (int p = 0; p < dcs_pkg::HALF_BRIDGES; p++) begin
            if (s.ctrl0[dcs_pkg::W0_STAGE_LO + 2 * p]
                && s.ctrl0[dcs_pkg::W0_STAGE_LO + 2 * p + 1]) begin
                want[2 * p] = 1'h0;
                want[2 * p + 1] = 1'h0;
            end
        end
        n.stage_on = hold_off ? '0 : want;
    end

    // the device counts as freshly woken out of reset
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            s <= '0;
            s.ctrl0 <= dcs_pkg::REG_RESET;
            s.ctrl1 <= dcs_pkg::REG_RESET;
            s.nrdy <= 1'h1;
        end else begin
            s <= n;
        end
    end

    assign o_stage_on = s.stage_on;

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rstn);

    sequence tsd_release;
        s.thermal_shutdown_flag ##1 !s.thermal_shutdown_flag;
    endsequence
    sequence oc_hit_any;
        i_overcurrent_event != '0;
    endsequence

    a_always_one: assert property (status0[dcs_pkg::S_ALWAYS_ONE] && status1[dcs_pkg::S_ALWAYS_ONE])
        else $error("status bit 15 not one");
    a_no_error: assert property ((s.oc_flag != '0 || s.thermal_shutdown_flag) |-> !status0[0] && !status1[0])
        else $error("no-error bit high with a fault set");
    a_ol_masked: assert property ((s.ctrl0[dcs_pkg::W0_OL_MASK] && s.oc_flag == '0 && !s.ov && !s.uv
                                   && !s.thermal_shutdown_flag && !s.twarn && !s.nrdy) |-> status1[0])
        else $error("masked open-load still raises fault");
    a_supply_off: assert property ((i_supply_overvoltage || i_supply_undervoltage)
                                   |=> o_stage_on == '0 && (s.ov || s.uv))
        else $error("stage on during supply fault");
    // a clear committed in this cycle may release the stages on the next one
    a_tsd_hold: assert property ((s.thermal_shutdown_flag && !clear_all) |=> o_stage_on == '0)
        else $error("stage on while thermal flag set");
    a_tsd_clear: assert property (tsd_release |-> $past(clear_all))
        else $error("thermal flag cleared without reset bit");
    a_wake_hold: assert property (i_standby_exit |=> s.nrdy ##1 o_stage_on == '0)
        else $error("stage on while not ready");
    a_bit9_zero: assert property (!status1[dcs_pkg::S_UNUSED] && !status0[dcs_pkg::S_UNUSED])
        else $error("status bit 9 not zero");
    a_oc_off: assert property (oc_hit_any |=> (o_stage_on & $past(i_overcurrent_event)) == '0
                               && (s.oc_flag & $past(i_overcurrent_event)) == $past(i_overcurrent_event))
        else $error("over-current stage not switched off");
    a_oc_retry: assert property ((retry && rec_en[7] && s.oc_lock[7] && !i_overcurrent_event[7])
                                 |=> !s.oc_lock[7])
        else $error("enabled recovery did not release the stage");
    a_pwm_gate: assert property ((pwm_en[1] && !i_pwm) |=> !o_stage_on[1])
        else $error("gated stage on while pwm low");
endmodule

// File: dcs_regs_top_tb.sv
module dcs_regs_top_tb;
    timeunit 1ns;
    timeprecision 100ps;

    localparam int OLC = 20;

    logic i_clk = 1'b0;
    logic i_rstn = 1'b0;
    logic sclk;
    logic chip_select_low_active;
    logic sdi;
    logic sdo;
    logic sdo_oe;
    logic rd_valid;
    logic [15:0] rd_word;
    logic [7:0] oc_ev = 8'h00;
    logic [7:0] below = 8'h00;
    logic [7:0] stage_on;
    logic ov = 1'b0;
    logic uv = 1'b0;
    logic thermal_shutdown_flag = 1'b0;
    logic warn = 1'b0;
    logic wake = 1'b0;
    logic pwm = 1'b0;
    int num_errors = 0;
    int num_checks = 0;
    int cycles = 0;
    logic [15:0] exp_q[$];

    // 250 MHz core clock
    always #2 i_clk = ~i_clk;

    dcs_regs_top #(
        .OL_FILTER_CYC(OLC),
        .SETTLE_CYC(10),
        .REC_DELAY_CYC(8)
    ) uut (
        .i_clk(i_clk),
        .i_rstn(i_rstn),
        .i_sclk(sclk),
        .i_chip_select_low_active(chip_select_low_active),
        .i_sdi(sdi),
        .o_sdo(sdo),
        .o_sdo_oe(sdo_oe),
        .i_overcurrent_event(oc_ev),
        .i_load_below_threshold(below),
        .i_supply_overvoltage(ov),
        .i_supply_undervoltage(uv),
        .i_thermal_shutdown(thermal_shutdown_flag),
        .i_temp_warning(warn),
        .i_standby_exit(wake),
        .i_pwm(pwm),
        .o_stage_on(stage_on)
    );

    dcs_host_model host (
        .i_clk(i_clk),
        .o_sclk(sclk),
        .o_chip_select_low_active(chip_select_low_active),
        .o_sdi(sdi),
        .i_sdo(sdo),
        .i_sdo_oe(sdo_oe),
        .o_rd_valid(rd_valid),
        .o_rd_word(rd_word)
    );

    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // inputs move one ns after the edge, away from sampling
    task automatic tick(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask

    task automatic stage(input logic [7:0] exp);
        check("stage drive", {8'h00, stage_on}, {8'h00, exp});
    endtask

    // note the expected status word, then run the frame
    task automatic xfer(input logic [15:0] w, input logic [15:0] exp, input int ph);
        exp_q.push_back(exp);
        host.frame(w, 16, ph);
    endtask

    // each finished read is matched against the oldest note
    always @(posedge i_clk) begin
        if (rd_valid === 1'b1) begin
            check("status word", rd_word, exp_q.pop_front());
        end
    end

    // hang guard, generous against the expected run length
    always @(posedge i_clk) begin
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            report_and_stop();
        end
    end

    initial begin
        logic [7:0] r;
        void'($urandom(32'h3fd4));
        tick(2);
        i_rstn = 1'b1;
        tick(20);
        // clean status, then odd-length frames must leave no trace
        xfer(16'h0001, 16'h8001, 2);
        host.frame(16'h0004, 15, 2);
        stage(8'h00);
        host.frame(16'h0004, 17, 2);
        stage(8'h00);
        xfer(16'h0004, 16'h8001, 5);
        stage(8'h02);
        // random high-side patterns, never both halves of a bridge
        repeat (3) begin
            r = 8'($urandom()) & 8'hEA;
            xfer({7'h00, r, 1'b0}, 16'h8001, 2);
            stage(r);
        end
        xfer(16'h01D4, 16'h8001, 2);
        // gating follows the pwm level; upper bits of word two do nothing
        xfer(16'h003F, 16'h8001, 2);
        stage(8'h00);
        pwm = 1'b1;
        tick(3);
        stage(8'hEA);
        pwm = 1'b0;
        xfer(16'hF801, 16'h8001, 2);
        stage(8'hEA);
        // over-current on output five, recovery off then on
        oc_ev = 8'h80;
        tick(1);
        oc_ev = 8'h00;
        tick(2);
        stage(8'h6A);
        xfer(16'h01D4, 16'h8100, 2);
        stage(8'h6A); // never enabled, so no retry
        xfer(16'h0401, 16'h8000, 2);
        for (int i = 0; i < 40 && stage_on[7] !== 1'b1; i++) begin
            tick(1);
        end
        stage(8'hEA);
        xfer(16'h0001, 16'h8000, 2);
        xfer(16'h81D4, 16'h8100, 2);
        xfer(16'h0001, 16'h8001, 2);
        // warning is only reported, shutdown holds until cleared
        warn = 1'b1;
        tick(1);
        warn = 1'b0;
        xfer(16'h0001, 16'h8800, 2);
        stage(8'hEA);
        thermal_shutdown_flag = 1'b1;
        tick(1);
        thermal_shutdown_flag = 1'b0;
        tick(2);
        stage(8'h00);
        xfer(16'h0001, 16'h9800, 2);
        stage(8'h00);
        xfer(16'h81D4, 16'h9800, 2);
        stage(8'hEA);
        // supply faults: both flags latch, outputs follow the live level
        ov = 1'b1;
        tick(3);
        stage(8'h00);
        ov = 1'b0;
        uv = 1'b1;
        xfer(16'h0001, 16'hE000, 2);
        stage(8'h00);
        uv = 1'b0;
        xfer(16'h81D4, 16'hE000, 2);
        stage(8'hEA);
        // a brief probe below the filter time flags nothing
        below = 8'h08;
        tick(OLC - 3);
        below = 8'h00;
        xfer(16'h0001, 16'h8001, 2);
        below = 8'hEA;
        tick(OLC + 4);
        xfer(16'h0001, 16'h81D4, 2);
        xfer(16'h41D4, 16'h8000, 2);
        xfer(16'h0001, 16'h81D5, 2);
        below = 8'h00;
        xfer(16'h81D4, 16'h8001, 2);
        // wake from standby: outputs wait for the settle timer
        wake = 1'b1;
        tick(1);
        wake = 1'b0;
        tick(1);
        stage(8'h00);
        xfer(16'h0001, 16'h8400, 2);
        stage(8'hEA);
        xfer(16'h0001, 16'h8001, 2);
        report_and_stop();
    end
endmodule

// File: dcs_serial_port.sv
module dcs_serial_port (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rstn,
    // serial link pins, sampled on the core clock
    input wire logic i_sclk,
    input wire logic i_chip_select_low_active,
    input wire logic i_sdi,
    output logic o_sdo,
    output logic o_sdo_oe,
    // status words to shift out
    input wire logic [15:0] i_status0,
    input wire logic [15:0] i_status1,
    // received frame
    output logic o_frame_valid,
    output logic [15:0] o_frame_word
);
    typedef struct packed {
        logic sclk_prev;
        logic cs_prev;
        logic [4:0] cnt;
        logic [15:0] shift_in;
        logic [15:0] shift_out;
        logic sdo;
        logic sdo_oe;
        logic fv;
        logic [15:0] fword;
    } dcs_port_state_type;

    dcs_port_state_type s;
    dcs_port_state_type n;

    // lsb first in both directions; out data moves on falling clock edges
    always_comb begin
        n = s;
        n.fv = 1'h0;
        n.sclk_prev = i_sclk;
        n.cs_prev = i_chip_select_low_active;
        if (!i_chip_select_low_active) begin
            n.sdo_oe = 1'h1;
            if (s.cs_prev) begin
                n.cnt = '0;
                n.sdo = i_status0[dcs_pkg::S_NOERR];
            end else if (i_sclk && !s.sclk_prev) begin
                n.shift_in = {i_sdi, s.shift_in[15:1]};
                if (s.cnt == '0) begin
                    n.shift_out = i_sdi ? i_status1 : i_status0;
                end
                if (s.cnt != dcs_pkg::FRAME_SAT) begin
                    n.cnt = s.cnt + 1'h1;
                end
            end else if (!i_sclk && s.sclk_prev && s.cnt != '0) begin
                n.shift_out = {1'h0, s.shift_out[15:1]};
                n.sdo = s.shift_out[1];
            end else if (s.cnt == '0) begin
                n.sdo = i_status0[dcs_pkg::S_NOERR]; // fault poll without clocks
            end
        end else begin
            n.sdo_oe = 1'h0;
            n.sdo = 1'h0;
            // a wrong count drops the frame so stages never switch on garbage
            if (!s.cs_prev && s.cnt == dcs_pkg::FRAME_LEN) begin
                n.fv = 1'h1;
                n.fword = s.shift_in;
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            s <= '0;
            s.cs_prev <= 1'h1;
        end else begin
            s <= n;
        end
    end

    assign o_sdo = s.sdo;
    assign o_sdo_oe = s.sdo_oe;
    assign o_frame_valid = s.fv;
    assign o_frame_word = s.fword;

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rstn);

    sequence good_end;
        !i_chip_select_low_active ##1 (i_chip_select_low_active && s.cnt == dcs_pkg::FRAME_LEN);
    endsequence
    sequence bad_end;
        !i_chip_select_low_active ##1 (i_chip_select_low_active && s.cnt != dcs_pkg::FRAME_LEN);
    endsequence

    a_frame_commit: assert property (good_end |=> o_frame_valid && o_frame_word == $past(s.shift_in))
        else $error("sixteen-bit frame not committed");
    a_frame_discard: assert property (bad_end |=> !o_frame_valid)
        else $error("frame of wrong length committed");
endmodule
